// ===== rtl/owb_engine.sv
// Byte write/read engine for the single-wire master
`timescale 1ns/1ps
module owb_engine #(
   parameter int SLOT_CYC = owb_pkg::STD_SLOT_CYC,
   parameter int LOW1_CYC = owb_pkg::STD_LOW1_CYC,
   parameter int LOW0_CYC = owb_pkg::STD_LOW0_CYC,
   parameter int MSR_CYC = owb_pkg::STD_MSR_CYC,
   parameter int OD_SLOT_CYC = owb_pkg::OD_SLOT_CYC,
   parameter int OD_LOW1_CYC = owb_pkg::OD_LOW1_CYC,
   parameter int OD_LOW0_CYC = owb_pkg::OD_LOW0_CYC,
   parameter int OD_MSR_CYC = owb_pkg::OD_MSR_CYC
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic srst_in,
   // Command from the host side decoder
   input wire logic cmd_valid_in,
   input wire logic [7:0] cmd_code_in,
   input wire logic data_valid_in,
   input wire logic [7:0] data_in,
   output logic cmd_ack_out,
   output logic data_ack_out,
   // Configuration
   input wire logic overdrive_speed_select_in,
   input wire logic strong_pullup_enable_in,
   input wire logic active_pullup_enable_in,
   // Status
   output logic line_busy_flag_out,
   output logic sampled_bit_result_out,
   output logic [7:0] read_data_out,
   output owb_pkg::owb_ptr_t read_ptr_out,
   input wire logic set_ptr_rd_data_in,
   // Single-wire line
   input wire logic line_in,
   output logic line_out,
   output logic line_oe_out,
   output logic active_pullup_out,
   output logic strong_pullup_out
);
   typedef enum logic [1:0] {OWB_IDLE, OWB_WAIT_DATA, OWB_SLOTS} owb_state_t;
   localparam int CW = $clog2((SLOT_CYC > OD_SLOT_CYC ? SLOT_CYC
      : OD_SLOT_CYC) + 1);

   owb_state_t state_r;
   logic is_read_r;
   logic [7:0] shift_r;
   logic [2:0] bit_r;
   logic [CW-1:0] cnt_r;
   logic [7:0] read_data_r;
   logic sbr_r;
   logic od_r;
   logic spu_r;
   logic apu_r;
   owb_pkg::owb_ptr_t ptr_r;
   logic line_s1_r;
   logic line_s2_r;
   logic [CW-1:0] slot_len;
   logic [CW-1:0] low_len;
   logic [CW-1:0] msr_pt;
   logic [7:0] slot_byte;
   logic cur_bit;
   logic accept_cmd;
   logic slot_end;

   // Accept only while the line is idle; a busy line gets no ack
   assign accept_cmd = cmd_valid_in && (state_r == OWB_IDLE);
   assign cmd_ack_out = accept_cmd &&
      (cmd_code_in == owb_pkg::CMD_WRITE_BYTE ||
       cmd_code_in == owb_pkg::CMD_READ_BYTE);
   assign data_ack_out = data_valid_in && (state_r == OWB_WAIT_DATA);

   // Speed latched per command so a mid-byte change cannot warp a slot
   assign slot_len = od_r ? CW'(OD_SLOT_CYC) : CW'(SLOT_CYC);
   // Each slot is built like a single-bit slot; only the top bit counts
   assign slot_byte = is_read_r ? 8'hFF : {shift_r[0], 7'h00};
   assign cur_bit = slot_byte[owb_pkg::BIT_VALUE_POS];
   assign low_len = cur_bit ? (od_r ? CW'(OD_LOW1_CYC) : CW'(LOW1_CYC))
                            : (od_r ? CW'(OD_LOW0_CYC) : CW'(LOW0_CYC));
   assign msr_pt = od_r ? CW'(OD_MSR_CYC) : CW'(MSR_CYC);
   assign slot_end = (state_r == OWB_SLOTS) && (cnt_r == slot_len - 1'b1);

   // Line input synchroniser
   always_ff @(posedge ref_clk_in) begin
      line_s1_r <= line_in;
      line_s2_r <= line_s1_r;
   end

   // Command sequencing
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         state_r <= OWB_IDLE;
         is_read_r <= 1'b0;
         shift_r <= 8'h00;
         bit_r <= 3'h0;
         cnt_r <= '0;
         od_r <= 1'b0;
         spu_r <= 1'b0;
         apu_r <= 1'b0;
      end else begin
         unique case (state_r)
            OWB_IDLE: begin
               cnt_r <= '0;
               bit_r <= 3'h0;
               if (cmd_ack_out) begin
                  od_r <= overdrive_speed_select_in;
                  spu_r <= strong_pullup_enable_in;
                  apu_r <= active_pullup_enable_in;
                  if (cmd_code_in == owb_pkg::CMD_WRITE_BYTE) begin
                     is_read_r <= 1'b0;
                     state_r <= OWB_WAIT_DATA;
                  end else begin
                     // Read-byte starts the cycle after the code ack
                     is_read_r <= 1'b1;
                     spu_r <= 1'b0;
                     state_r <= OWB_SLOTS;
                  end
               end
            end
            OWB_WAIT_DATA: begin
               if (data_valid_in) begin
                  // Full byte in hand, slots start next cycle
                  shift_r <= data_in;
                  state_r <= OWB_SLOTS;
               end
            end
            OWB_SLOTS: begin
               if (slot_end) begin
                  cnt_r <= '0;
                  shift_r <= {1'b0, shift_r[7:1]};
                  bit_r <= bit_r + 3'h1;
                  if (bit_r == 3'h7) begin
                     state_r <= OWB_IDLE;
                  end
               end else begin
                  cnt_r <= cnt_r + 1'b1;
               end
            end
            default: state_r <= OWB_IDLE;
         endcase
      end
   end

   // Line sampling and read data assembly
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         sbr_r <= 1'b0;
         read_data_r <= owb_pkg::RD_DATA_RST;
      end else if (state_r == OWB_SLOTS && cnt_r == msr_pt && cur_bit) begin
         sbr_r <= line_s2_r;
         if (is_read_r) begin
            read_data_r[bit_r] <= line_s2_r;
         end
      end
   end

   // Read pointer
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         ptr_r <= owb_pkg::OWB_PTR_STATUS;
      end else if (cmd_ack_out) begin
         ptr_r <= owb_pkg::OWB_PTR_STATUS;
      end else if (set_ptr_rd_data_in) begin
         ptr_r <= owb_pkg::OWB_PTR_READ_DATA;
      end
   end

   // Line drive: open drain low during the slot's low phase
   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         line_oe_out <= 1'b0;
         active_pullup_out <= 1'b0;
         strong_pullup_out <= 1'b0;
      end else begin
         line_oe_out <= (state_r == OWB_SLOTS) && (cnt_r < low_len);
         active_pullup_out <= apu_r && (state_r == OWB_SLOTS) &&
            (cnt_r >= low_len);
         // Strong pullup only after the last written bit
         strong_pullup_out <= (spu_r && !is_read_r &&
            (state_r == OWB_IDLE) && strong_pullup_out) ||
            (spu_r && slot_end && bit_r == 3'h7 && !is_read_r);
      end
   end

   assign line_out = 1'b0;
   assign line_busy_flag_out = (state_r == OWB_SLOTS);
   assign sampled_bit_result_out = sbr_r;
   assign read_data_out = read_data_r;
   assign read_ptr_out = ptr_r;

   // Checks
   AST_BUSY_NO_ACK: assert property (@(posedge ref_clk_in) disable iff
      (srst_in) line_busy_flag_out |-> !cmd_ack_out)
      else $error("Command acked while busy");
   AST_RD_NO_ACK: assert property (@(posedge ref_clk_in) disable iff
      (srst_in) (line_busy_flag_out &&
      cmd_code_in == owb_pkg::CMD_READ_BYTE) |->
      !cmd_ack_out)
      else $error("Read acked while busy");
   AST_WR_START: assert property (@(posedge ref_clk_in) disable iff
      (srst_in) (state_r == OWB_WAIT_DATA && data_valid_in) |=>
      line_busy_flag_out ##1 line_oe_out)
      else $error("Write slots late");
   AST_RD_START: assert property (@(posedge ref_clk_in) disable iff
      (srst_in) (cmd_ack_out && cmd_code_in == owb_pkg::CMD_READ_BYTE) |=>
      line_busy_flag_out ##1 line_oe_out)
      else $error("Read slots late");
   AST_PTR_STATUS: assert property (@(posedge ref_clk_in) disable iff
      (srst_in) cmd_ack_out |=> ptr_r == owb_pkg::OWB_PTR_STATUS)
      else $error("Pointer not at status");
   AST_BUSY_END: assert property (@(posedge ref_clk_in) disable iff
      (srst_in) (slot_end && bit_r == 3'h7) |=> !line_busy_flag_out)
      else $error("Busy not cleared");
   AST_BUSY_HOLD: assert property (@(posedge ref_clk_in) disable iff
      (srst_in) (line_busy_flag_out && !(slot_end && bit_r == 3'h7)) |=>
      line_busy_flag_out)
      else $error("Busy dropped early");
   AST_SHIFT_LSB: assert property (@(posedge ref_clk_in) disable iff
      (srst_in) (slot_end && !is_read_r) |=> shift_r[6:0] ==
      $past(shift_r[7:1]))
      else $error("Bit order wrong");
   AST_SAMPLE: assert property (@(posedge ref_clk_in) disable iff
      (srst_in) (state_r == OWB_SLOTS && cnt_r == msr_pt && cur_bit) |=>
      sbr_r == $past(line_s2_r))
      else $error("Sample lost");
   COV_WRITE: cover property (@(posedge ref_clk_in)
      cmd_ack_out && cmd_code_in == owb_pkg::CMD_WRITE_BYTE);
   COV_READ: cover property (@(posedge ref_clk_in)
      cmd_ack_out && cmd_code_in == owb_pkg::CMD_READ_BYTE);
   COV_REFUSE: cover property (@(posedge ref_clk_in)
      cmd_valid_in && line_busy_flag_out);
endmodule

// ===== rtl/owb_pkg.sv
// Package: constants for the single-wire byte write/read engine
// How it works
// - Slot value in bit 7, rest ignored
// - Code A5h with data byte writes byte
// - Busy at write code: no ack, discard
// - Write finishes within eight slots plus margin
// - Write activity starts soon after last bit
// - Wait for whole byte; send LSB first
// - Accepted command points read pointer at status
// - Busy held for all eight slots, then cleared
// - Write slots honour speed and pullup settings
// - Code 96h reads eight slots into register
// - Read slots are sampled write-one slots
// - Busy at read code: no ack, ignore
// - Read activity starts soon after ack edge
// - Write-one slot samples line at sample time
package owb_pkg;
   localparam logic [7:0] CMD_WRITE_BYTE = 8'hA5;
   localparam logic [7:0] CMD_READ_BYTE = 8'h96;
   localparam int BIT_VALUE_POS = 7;
   localparam real CLK_NS = 5.0;
   localparam real START_MAX_NS = 262.5;
   // Rounded down so the start never lands past the allowed margin
   localparam int START_MAX_CYC = int'($floor(START_MAX_NS / CLK_NS));
   // Standard speed slot timings in ns
   localparam real STD_SLOT_NS = 70000.0;
   localparam real STD_LOW1_NS = 6000.0;
   localparam real STD_LOW0_NS = 60000.0;
   localparam real STD_MSR_NS = 15000.0;
   // Overdrive slot timings in ns
   localparam real OD_SLOT_NS = 10000.0;
   localparam real OD_LOW1_NS = 1000.0;
   localparam real OD_LOW0_NS = 7500.0;
   localparam real OD_MSR_NS = 2000.0;
   localparam int STD_SLOT_CYC = int'($ceil(STD_SLOT_NS / CLK_NS));
   localparam int STD_LOW1_CYC = int'($ceil(STD_LOW1_NS / CLK_NS));
   localparam int STD_LOW0_CYC = int'($ceil(STD_LOW0_NS / CLK_NS));
   localparam int STD_MSR_CYC = int'($floor(STD_MSR_NS / CLK_NS));
   localparam int OD_SLOT_CYC = int'($ceil(OD_SLOT_NS / CLK_NS));
   localparam int OD_LOW1_CYC = int'($ceil(OD_LOW1_NS / CLK_NS));
   localparam int OD_LOW0_CYC = int'($ceil(OD_LOW0_NS / CLK_NS));
   localparam int OD_MSR_CYC = int'($floor(OD_MSR_NS / CLK_NS));
   localparam logic [7:0] RD_DATA_RST = 8'h00;
   typedef enum logic {OWB_PTR_STATUS, OWB_PTR_READ_DATA} owb_ptr_t;
endpackage

// ===== bench/owb_slave_model.sv
// Behavioural single-wire slave: decodes written slots, answers reads
`timescale 1ns/1ps
module owb_slave_model (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Line as seen by the slave
   input wire logic master_low_in,
   input wire logic rd_en_in,
   input wire logic [7:0] tx_byte_in,
   input wire logic od_in,
   output logic pull_low_out,
   output logic [7:0] rx_byte_out
);
   logic prev_r;
   logic bit_r;
   logic [2:0] idx_r;
   int age_r;
   // Bench shrinks standard slots; overdrive keeps package timing
   localparam int ONE_MAX = 10;
   localparam int OD_ONE_MAX =
      (owb_pkg::OD_LOW1_CYC + owb_pkg::OD_LOW0_CYC) / 2;
   // Holds past the shrunk standard-speed sample point yet frees the line well before slot end
   assign pull_low_out = rd_en_in && !bit_r && age_r < 16;
   always_ff @(posedge clk_in) begin
      prev_r <= master_low_in;
      if (rst_in) begin
         age_r <= 100;
         idx_r <= 3'h0;
         bit_r <= 1'b1;
         rx_byte_out <= 8'h00;
      end else if (master_low_in && !prev_r) begin
         age_r <= 1;
         bit_r <= tx_byte_in[idx_r];
         idx_r <= idx_r + 3'h1;
      end else begin
         age_r <= age_r + 1;
         // Short low is a one; bits arrive low first
         if (!master_low_in && prev_r)
            rx_byte_out <= {age_r < (od_in ? OD_ONE_MAX : ONE_MAX),
               rx_byte_out[7:1]};
      end
   end
endmodule

// ===== bench/test_onewire_byte_write_read.sv
// Testbench for the single-wire byte write/read engine
`timescale 1ns/1ps
module test_onewire_byte_write_read;
   logic clk = 0, rst = 1, cv = 0, dv = 0, od = 0, strong_pullup_enable = 0, active_pullup_enable = 1;
   logic sp = 0, rd = 0;
   logic [7:0] code = 8'h00, d = 8'h00, tx = 8'h00;
   logic cack, dack, busy, sampled_bit_result, lo, oe, apo, spo, pull;
   logic [7:0] rdd, rx;
   owb_pkg::owb_ptr_t ptr;
   wire line = !(oe | pull);
   int n_fail = 0, checked = 0;
   // Standard slots shrunk for run time; overdrive uses its defaults
   localparam int T_SLOT = 40;
   localparam int T_LOW1 = 4;
   localparam int T_LOW0 = 30;
   localparam int T_MSR = 10;
   owb_engine #(.SLOT_CYC(T_SLOT), .LOW1_CYC(T_LOW1), .LOW0_CYC(T_LOW0),
      .MSR_CYC(T_MSR)) DUT (.ref_clk_in(clk), .srst_in(rst),
      .cmd_valid_in(cv), .cmd_code_in(code), .data_valid_in(dv),
      .data_in(d), .cmd_ack_out(cack), .data_ack_out(dack),
      .overdrive_speed_select_in(od), .strong_pullup_enable_in(strong_pullup_enable),
      .active_pullup_enable_in(active_pullup_enable), .line_busy_flag_out(busy),
      .sampled_bit_result_out(sampled_bit_result), .read_data_out(rdd),
      .read_ptr_out(ptr), .set_ptr_rd_data_in(sp), .line_in(line),
      .line_out(lo), .line_oe_out(oe), .active_pullup_out(apo),
      .strong_pullup_out(spo));
   owb_slave_model slave (.clk_in(clk), .rst_in(rst), .master_low_in(oe),
      .rd_en_in(rd), .tx_byte_in(tx), .od_in(od), .pull_low_out(pull),
      .rx_byte_out(rx));
   initial begin
      forever #2.5 clk = ~clk;
   end
   task chk(input string w, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", w, e, g);
      end
   endtask
   task end_of_test;
      if (n_fail == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // One accepted command, a refused probe mid-run, busy span measured
   task run(input logic [7:0] c, input logic [7:0] v, input int slot,
         input logic [7:0] probe);
      int n, act;
      logic ap;
      n = 0;
      act = -1;
      ap = 0;
      @(posedge clk);
      cv <= 1;
      code <= c;
      #1 chk("cmd_ack", 1, cack);
      @(posedge clk);
      cv <= 0;
      dv <= (c == owb_pkg::CMD_WRITE_BYTE);
      d <= v;
      #1 if (dv) chk("data_ack", 1, dack);
      // Read-byte is already busy here
      n += busy;
      for (int i = 0; i < 20000 && !(n > 0 && !busy); i++) begin
         @(posedge clk);
         dv <= 0;
         cv <= (i == 6);
         code <= probe;
         #1 if (i == 6) chk("busy refusal", 0, cack);
         if (oe && act < 0) act = i;
         n += busy;
         ap |= apo;
      end
      chk("busy span", 16'(8 * slot), 16'(n));
      chk("active pullup", 16'(active_pullup_enable), 16'(ap));
      chk("start", 1, act >= 0 && act < owb_pkg::START_MAX_CYC);
      chk("pointer", 16'(owb_pkg::OWB_PTR_STATUS), 16'(ptr));
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst <= 0;
      strong_pullup_enable <= 1;
      @(posedge clk);
      #1 chk("busy idle", 0, busy);
      run(owb_pkg::CMD_WRITE_BYTE, 8'hB4, T_SLOT,
         owb_pkg::CMD_READ_BYTE);
      chk("written byte", 8'hB4, rx);
      chk("strong pullup", 1, spo);
      chk("line out", 0, lo);
      @(posedge clk);
      sp <= 1;
      strong_pullup_enable <= 0;
      active_pullup_enable <= 0;
      rd <= 1;
      tx <= 8'hC3;
      @(posedge clk);
      sp <= 0;
      #1 chk("pointer", 16'(owb_pkg::OWB_PTR_READ_DATA), 16'(ptr));
      run(owb_pkg::CMD_READ_BYTE, 8'h00, T_SLOT,
         owb_pkg::CMD_WRITE_BYTE);
      chk("read byte", 8'hC3, rdd);
      chk("sampled bit", 1, sampled_bit_result);
      @(posedge clk);
      rd <= 0;
      od <= 1;
      active_pullup_enable <= 1;
      run(owb_pkg::CMD_WRITE_BYTE, 8'h01, owb_pkg::OD_SLOT_CYC,
         owb_pkg::CMD_READ_BYTE);
      chk("overdrive byte", 8'h01, rx);
      @(posedge clk);
      cv <= 1;
      code <= 8'h87;
      #1 chk("foreign code", 0, cack);
      @(posedge clk);
      cv <= 0;
      end_of_test;
   end
   initial begin
      // Overdrive byte alone takes about 16000 cycles
      repeat (25000) @(posedge clk);
      n_fail++;
      end_of_test;
   end
endmodule
